// file: rtl/rpfq_pkg.sv
package rpfq_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] PIPE4_RX_WIDTH_ADDR = 8'h15;
  localparam logic [7:0] PIPE5_RX_WIDTH_ADDR = 8'h16;
  localparam logic [7:0] QUEUE_STATUS_ADDR   = 8'h17;
  // ==========================================================
  // Field layout and limits
  localparam int unsigned WIDTH_FIELD_BITS  = 6;
  localparam logic [5:0]  WIDTH_MAX         = 6'h20;
  localparam int unsigned STAT_REUSE_BIT    = 6;
  localparam int unsigned STAT_TX_FULL_BIT  = 5;
  localparam int unsigned STAT_TX_EMPTY_BIT = 4;
  localparam int unsigned STAT_RX_FULL_BIT  = 1;
  localparam int unsigned STAT_RX_EMPTY_BIT = 0;
  localparam logic [7:0]  WIDTH_RESET       = 8'h00;
  localparam int unsigned QUEUE_LEVELS      = 3;
  localparam int unsigned PAYLOAD_BITS      = 256;
  localparam int unsigned PIPE_BITS         = 3;
  // ==========================================================
  // Timing
  localparam int unsigned CLOCK_MHZ         = 25;
  localparam int unsigned RESEND_PULSE_US   = 10;
  localparam int unsigned RESEND_PULSE_CYC  = RESEND_PULSE_US * CLOCK_MHZ;
  // ==========================================================
  // Commands
  typedef enum logic [2:0] {
    RPFQ_CMD_NONE,
    RPFQ_CMD_REG_WRITE,
    RPFQ_CMD_TX_WRITE,
    RPFQ_CMD_ACK_WRITE,
    RPFQ_CMD_RX_READ,
    RPFQ_CMD_FLUSH_TX,
    RPFQ_CMD_FLUSH_RX,
    RPFQ_CMD_RESEND_LAST
  } rpfq_cmd_type;
endpackage : rpfq_pkg

// file: rtl/rpfq_queue_if.sv
`timescale 1ns/1ps
interface rpfq_queue_if #(parameter int unsigned DW = 256);
  logic          push;
  logic [DW-1:0] pushData;
  logic          pop;
  logic          flush;
  logic [DW-1:0] headData;
  logic          full;
  logic          empty;
  logic [1:0]    count;
  modport owner (input push, pushData, pop, flush, output headData, full, empty, count);
  modport user  (output push, pushData, pop, flush, input headData, full, empty, count);
endinterface : rpfq_queue_if

// file: rtl/rpfq_queue.sv
`timescale 1ns/1ps
module rpfq_queue #(
  parameter int unsigned DW    = 256,
  parameter int unsigned DEPTH = 3
) (
  // Clock and reset
  input  wire logic   clock,
  input  wire logic   rst_n,
  input  wire logic   clkEn,
  // Queue port
  rpfq_queue_if.owner q
);
  // ==========================================================
  // Storage
  logic [DW-1:0] memFf [DEPTH];
  logic [1:0]    rdPtrFf, nxt_rdPtr, wrPtrFf, nxt_wrPtr, countFf, nxt_count;
  logic          doPush, doPop;

  if (DEPTH != 3) $error("rpfq_queue supports three levels only");

  // Push into a full queue is dropped so stored entries stay intact
  assign doPush = q.push && (countFf != 2'(DEPTH));
  assign doPop  = q.pop && (countFf != 2'h0);

  always_comb
  begin
    nxt_rdPtr = rdPtrFf;
    nxt_wrPtr = wrPtrFf;
    nxt_count = countFf;
    if (q.flush)
    begin
      nxt_rdPtr = 2'h0;
      nxt_wrPtr = 2'h0;
      nxt_count = 2'h0;
    end
    else
    begin
      if (doPush)
        nxt_wrPtr = (wrPtrFf == 2'(DEPTH - 1)) ? 2'h0 : wrPtrFf + 2'h1;
      if (doPop)
        nxt_rdPtr = (rdPtrFf == 2'(DEPTH - 1)) ? 2'h0 : rdPtrFf + 2'h1;
      nxt_count = countFf + {1'b0, doPush} - {1'b0, doPop};
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdPtrFf <= 2'h0;
      wrPtrFf <= 2'h0;
      countFf <= 2'h0;
    end
    else if (clkEn)
    begin
      rdPtrFf <= nxt_rdPtr;
      wrPtrFf <= nxt_wrPtr;
      countFf <= nxt_count;
    end
  end

  // Payload memory has no reset; contents are undefined until written
  always_ff @(posedge clock)
  begin
    if (clkEn && doPush && !q.flush)
      memFf[wrPtrFf] <= q.pushData;
  end

  assign q.headData = memFf[rdPtrFf];
  assign q.full     = (countFf == 2'(DEPTH));
  assign q.empty    = (countFf == 2'h0);
  assign q.count    = countFf;
endmodule : rpfq_queue

// file: rtl/rpfq_payload_fifo.sv
`timescale 1ns/1ps
module rpfq_payload_fifo #(
  parameter int unsigned DW          = rpfq_pkg::PAYLOAD_BITS,
  parameter int unsigned DEPTH       = rpfq_pkg::QUEUE_LEVELS,
  parameter int unsigned PULSE_CYC   = rpfq_pkg::RESEND_PULSE_CYC
) (
  // Clock, reset, enable
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic                  clkEn,
  // Command port from the microcontroller
  input  wire rpfq_pkg::rpfq_cmd_type cmd,
  input  wire logic [7:0]            cmdAddr,
  input  wire logic [7:0]            cmdWrData,
  input  wire logic [2:0]            cmdPipe,
  input  wire logic [DW-1:0]         cmdPayload,
  output logic [7:0]                 regRdData,
  output logic [DW-1:0]              rxRdPayload,
  // Role and chip enable
  input  wire logic                  txRole,
  input  wire logic                  chipEnable,
  // Radio core transmit side
  input  wire logic                  txDone,
  output logic                       txStart,
  output logic [DW-1:0]              txPayload,
  // Radio core receive side
  input  wire logic                  rxPush,
  input  wire logic [DW-1:0]         rxPayload,
  input  wire logic [2:0]            ackPipe,
  input  wire logic                  ackTaken,
  output logic                       ackValid,
  output logic [DW-1:0]              ackPayload,
  // Width configuration
  output logic [5:0]                 pipe4Width,
  output logic [5:0]                 pipe5Width
);
  // ==========================================================
  // Checks
  if (DEPTH != 3 || PULSE_CYC < 1) $error("rpfq_payload_fifo parameters unsupported");

  // ==========================================================
  // Queues
  rpfq_queue_if #(.DW(DW)) txQ ();
  rpfq_queue_if #(.DW(DW)) rxQ ();

  rpfq_queue #(.DW(DW), .DEPTH(DEPTH)) u_txq (.clock(clock), .rst_n(rst_n), .clkEn(clkEn), .q(txQ));
  rpfq_queue #(.DW(DW), .DEPTH(DEPTH)) u_rxq (.clock(clock), .rst_n(rst_n), .clkEn(clkEn), .q(rxQ));

  // ==========================================================
  // Register state
  logic [5:0] p4Ff, nxt_p4, p5Ff, nxt_p5;
  logic       reuseFf, nxt_reuse;
  logic [DW-1:0] lastFf, nxt_last;
  logic       busyFf, nxt_busy, resendFf, nxt_resend;
  logic [$clog2(PULSE_CYC+1)-1:0] ceCntFf, nxt_ceCnt;
  logic       ceLongFf, nxt_ceLong;
  logic       isTxWr, isFlushTx, isResend;

  assign isTxWr    = (cmd == rpfq_pkg::RPFQ_CMD_TX_WRITE);
  assign isFlushTx = (cmd == rpfq_pkg::RPFQ_CMD_FLUSH_TX);
  assign isResend  = (cmd == rpfq_pkg::RPFQ_CMD_RESEND_LAST);

  assign txQ.push     = isTxWr;
  assign txQ.pushData = cmdPayload;
  assign txQ.flush    = isFlushTx;
  // Queue is only drained by a finished send in the transmitter role
  assign txQ.pop      = txDone && busyFf && !resendFf && txRole;

  assign rxQ.push     = rxPush;
  assign rxQ.pushData = rxPayload;
  assign rxQ.pop      = (cmd == rpfq_pkg::RPFQ_CMD_RX_READ);
  assign rxQ.flush    = (cmd == rpfq_pkg::RPFQ_CMD_FLUSH_RX);

  always_comb
  begin
    nxt_p4 = p4Ff;
    nxt_p5 = p5Ff;
    // Width values above 32 are clamped since they cannot describe a payload
    if (cmd == rpfq_pkg::RPFQ_CMD_REG_WRITE)
    begin
      if (cmdAddr == rpfq_pkg::PIPE4_RX_WIDTH_ADDR)
        nxt_p4 = (cmdWrData[5:0] > rpfq_pkg::WIDTH_MAX) ? rpfq_pkg::WIDTH_MAX : cmdWrData[5:0];
      if (cmdAddr == rpfq_pkg::PIPE5_RX_WIDTH_ADDR)
        nxt_p5 = (cmdWrData[5:0] > rpfq_pkg::WIDTH_MAX) ? rpfq_pkg::WIDTH_MAX : cmdWrData[5:0];
    end
    // Transmit writes and transmit flush win over a same-cycle resend request
    nxt_reuse = reuseFf;
    if (isResend && txRole)
      nxt_reuse = 1'b1;
    if (isTxWr || isFlushTx)
      nxt_reuse = 1'b0;
    // Chip-enable pulse length qualifier
    nxt_ceCnt  = chipEnable ? ((ceCntFf == $bits(ceCntFf)'(PULSE_CYC)) ? ceCntFf : ceCntFf + 1'b1) : '0;
    nxt_ceLong = ceLongFf;
    if (chipEnable && ceCntFf == $bits(ceCntFf)'(PULSE_CYC - 1))
      nxt_ceLong = 1'b1;
    nxt_busy   = busyFf;
    nxt_resend = resendFf;
    nxt_last   = lastFf;
    if (busyFf && txDone)
      nxt_busy = 1'b0;
    else if (!busyFf && txRole)
    begin
      if (reuseFf && ceLongFf && !chipEnable)
      begin
        nxt_busy   = 1'b1;
        nxt_resend = 1'b1;
      end
      else if (!reuseFf && !txQ.empty)
      begin
        nxt_busy   = 1'b1;
        nxt_resend = 1'b0;
        nxt_last   = txQ.headData;
      end
    end
    if (!chipEnable)
      nxt_ceLong = 1'b0;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      p4Ff     <= rpfq_pkg::WIDTH_RESET[5:0];
      p5Ff     <= rpfq_pkg::WIDTH_RESET[5:0];
      reuseFf  <= 1'b0;
      busyFf   <= 1'b0;
      resendFf <= 1'b0;
      ceCntFf  <= '0;
      ceLongFf <= 1'b0;
      lastFf   <= '0;
    end
    else if (clkEn)
    begin
      p4Ff     <= nxt_p4;
      p5Ff     <= nxt_p5;
      reuseFf  <= nxt_reuse;
      busyFf   <= nxt_busy;
      resendFf <= nxt_resend;
      ceCntFf  <= nxt_ceCnt;
      ceLongFf <= nxt_ceLong;
      lastFf   <= nxt_last;
    end
  end

  assign txStart   = busyFf;
  assign txPayload = lastFf;
  assign pipe4Width = p4Ff;
  assign pipe5Width = p5Ff;

  // ==========================================================
  // Acknowledge payload slots, each tagged by pipe
  logic [DW-1:0] ackDataFf [DEPTH];
  logic [2:0]    ackPipeFf [DEPTH], nxt_ackPipe [DEPTH];
  logic [1:0]    ackAgeFf  [DEPTH], nxt_ackAge  [DEPTH];
  logic [DEPTH-1:0] ackVldFf, nxt_ackVld, slotFree, slotMatch, slotOldest;
  logic [1:0]    freeIdx, hitIdx, ackCount;
  logic          ackWr, ackFull, ackHit;

  assign ackWr = (cmd == rpfq_pkg::RPFQ_CMD_ACK_WRITE);

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++)
    begin : g_slot
      assign slotFree[gi]  = !ackVldFf[gi];
      assign slotMatch[gi] = ackVldFf[gi] && ackPipeFf[gi] == ackPipe;
    end
  endgenerate

  always_comb
  begin
    ackCount = 2'({1'b0, ackVldFf[0]} + {1'b0, ackVldFf[1]} + {1'b0, ackVldFf[2]});
    ackFull  = (ackCount == 2'(DEPTH));
    freeIdx  = slotFree[0] ? 2'h0 : (slotFree[1] ? 2'h1 : 2'h2);
    // Oldest matching entry leaves first: age counts entries ahead of it
    slotOldest = '0;
    for (int i = 0; i < DEPTH; i++)
    begin
      slotOldest[i] = slotMatch[i];
      for (int j = 0; j < DEPTH; j++)
        if (slotMatch[j] && ackAgeFf[j] < ackAgeFf[i])
          slotOldest[i] = 1'b0;
    end
    ackHit = |slotOldest && !txRole;
    hitIdx = slotOldest[0] ? 2'h0 : (slotOldest[1] ? 2'h1 : 2'h2);
    nxt_ackVld = ackVldFf;
    for (int i = 0; i < DEPTH; i++)
    begin
      nxt_ackPipe[i] = ackPipeFf[i];
      nxt_ackAge[i]  = ackAgeFf[i];
    end
    if (ackTaken && ackHit)
    begin
      nxt_ackVld[hitIdx] = 1'b0;
      for (int i = 0; i < DEPTH; i++)
        if (ackAgeFf[i] > ackAgeFf[hitIdx] && ackAgeFf[i] != 2'h0)
          nxt_ackAge[i] = ackAgeFf[i] - 2'h1;
    end
    if (ackWr && !ackFull)
    begin
      nxt_ackVld[freeIdx]  = 1'b1;
      nxt_ackPipe[freeIdx] = cmdPipe;
      nxt_ackAge[freeIdx]  = (ackTaken && ackHit) ? ackCount - 2'h1 : ackCount;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ackVldFf <= '0;
      for (int i = 0; i < DEPTH; i++)
      begin
        ackPipeFf[i] <= 3'h0;
        ackAgeFf[i]  <= 2'h0;
      end
    end
    else if (clkEn)
    begin
      ackVldFf <= nxt_ackVld;
      for (int i = 0; i < DEPTH; i++)
      begin
        ackPipeFf[i] <= nxt_ackPipe[i];
        ackAgeFf[i]  <= nxt_ackAge[i];
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (clkEn && ackWr && !ackFull)
      ackDataFf[freeIdx] <= cmdPayload;
  end

  assign ackValid   = ackHit;
  assign ackPayload = ackDataFf[hitIdx];

  // ==========================================================
  // Read side; reserved status bits read zero
  always_comb
  begin
    regRdData = 8'h00;
    case (cmdAddr)
      rpfq_pkg::PIPE4_RX_WIDTH_ADDR: regRdData = {2'h0, p4Ff};
      rpfq_pkg::PIPE5_RX_WIDTH_ADDR: regRdData = {2'h0, p5Ff};
      rpfq_pkg::QUEUE_STATUS_ADDR:
      begin
        regRdData[rpfq_pkg::STAT_REUSE_BIT]    = reuseFf;
        regRdData[rpfq_pkg::STAT_TX_FULL_BIT]  = txQ.full;
        regRdData[rpfq_pkg::STAT_TX_EMPTY_BIT] = txQ.empty;
        regRdData[rpfq_pkg::STAT_RX_FULL_BIT]  = rxQ.full;
        regRdData[rpfq_pkg::STAT_RX_EMPTY_BIT] = rxQ.empty;
      end
      default: regRdData = 8'h00;
    endcase
  end
  assign rxRdPayload = rxQ.headData;

  // ==========================================================
  // Checks on behaviour
  property p_tx_full_flag;
    @(posedge clock) disable iff (!rst_n)
    clkEn && isTxWr && !isFlushTx && !txQ.pop && txQ.count == 2'h2 |=> txQ.full;
  endproperty
  a_tx_full_flag: assert property (p_tx_full_flag) else $error("tx full not raised");

  property p_tx_empty_after_flush;
    @(posedge clock) disable iff (!rst_n)
    clkEn && isFlushTx |=> txQ.empty && !reuseFf;
  endproperty
  a_tx_empty_after_flush: assert property (p_tx_empty_after_flush) else $error("flush left data");

  property p_full_write_ignored;
    @(posedge clock) disable iff (!rst_n)
    clkEn && txQ.full && isTxWr && !txQ.pop && !isFlushTx |=> txQ.full && $stable(txQ.count);
  endproperty
  a_full_write_ignored: assert property (p_full_write_ignored) else $error("write into full queue");

  property p_reuse_set;
    @(posedge clock) disable iff (!rst_n)
    clkEn && isResend && txRole && !isTxWr && !isFlushTx |=> reuseFf;
  endproperty
  a_reuse_set: assert property (p_reuse_set) else $error("reuse not set");

  property p_reuse_clear;
    @(posedge clock) disable iff (!rst_n)
    clkEn && (isTxWr || isFlushTx) |=> !reuseFf;
  endproperty
  a_reuse_clear: assert property (p_reuse_clear) else $error("reuse not cleared");

  property p_ack_limit;
    @(posedge clock) disable iff (!rst_n)
    clkEn && ackWr && ackFull && !ackTaken |=> $stable(ackVldFf);
  endproperty
  a_ack_limit: assert property (p_ack_limit) else $error("too many ack payloads");

  property p_ack_rx_only;
    @(posedge clock) disable iff (!rst_n)
    txRole |-> !ackValid;
  endproperty
  a_ack_rx_only: assert property (p_ack_rx_only) else $error("ack payload in tx role");

  property p_tx_pop_tx_only;
    @(posedge clock) disable iff (!rst_n)
    !txRole && !txStart |=> !txStart && !txQ.pop;
  endproperty
  a_tx_pop_tx_only: assert property (p_tx_pop_tx_only) else $error("tx queue drained in rx role");

  property p_width_limit;
    @(posedge clock) disable iff (!rst_n)
    p4Ff <= rpfq_pkg::WIDTH_MAX && p5Ff <= rpfq_pkg::WIDTH_MAX;
  endproperty
  a_width_limit: assert property (p_width_limit) else $error("pipe width above 32");

  property p_rx_empty_flag;
    @(posedge clock) disable iff (!rst_n)
    clkEn && rxQ.flush |=> rxQ.empty && !rxQ.full;
  endproperty
  a_rx_empty_flag: assert property (p_rx_empty_flag) else $error("rx flush failed");
endmodule : rpfq_payload_fifo

// file: bench/rpfq_radio_model.sv
`timescale 1ns/1ps
module rpfq_radio_model (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Transmit handshake with the queue block
  input  wire logic         txStart,
  input  wire logic [255:0] txPayload,
  input  wire logic [3:0]   sendDelay,
  output logic              txDone,
  // Observation for the bench
  output logic [255:0]      sentPayload,
  output logic [7:0]        sentCount
);
  logic       busy_ff;
  logic [3:0] wait_ff;
  // ==========================================================
  // Air send timing
  // Done is followed by one idle edge so a txStart still high is not taken as a new send
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_ff     <= 1'b0;
      wait_ff     <= 4'h0;
      txDone      <= 1'b0;
      sentPayload <= '0;
      sentCount   <= 8'h00;
    end
    else if (txDone)
      txDone <= 1'b0;
    else if (!busy_ff && txStart)
    begin
      busy_ff <= 1'b1;
      wait_ff <= sendDelay;
    end
    else if (busy_ff && wait_ff == 4'h0)
    begin
      busy_ff     <= 1'b0;
      txDone      <= 1'b1;
      sentPayload <= txPayload;
      sentCount   <= sentCount + 8'h01;
    end
    else if (busy_ff)
      wait_ff <= wait_ff - 4'h1;
  end
endmodule : rpfq_radio_model

// file: bench/radio_payload_fifo_status_tb_top.sv
`timescale 1ns/1ps
module radio_payload_fifo_status_tb_top;
  localparam int unsigned PULSE = 4;
  logic                   clock = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   clkEn = 1'b1;
  rpfq_pkg::rpfq_cmd_type cmd = rpfq_pkg::RPFQ_CMD_NONE;
  logic [7:0]             cmdAddr = 8'h00;
  logic [7:0]             cmdWrData = 8'h00;
  logic [2:0]             cmdPipe = 3'h0;
  logic [255:0]           cmdPayload = '0;
  logic                   txRole = 1'b0;
  logic                   chipEnable = 1'b0;
  logic                   rxPush = 1'b0;
  logic [255:0]           rxPayload = '0;
  logic [2:0]             ackPipe = 3'h0;
  logic                   ackTaken = 1'b0;
  logic [3:0]             sendDelay = 4'h0;
  logic [7:0]             regRdData, sentCount;
  logic [255:0]           rxRdPayload, txPayload, ackPayload, sentPayload;
  logic                   txStart, txDone, ackValid;
  logic [5:0]             pipe4Width, pipe5Width;
  logic [31:0]            seed = 32'h53c7;
  logic [255:0]           pl [4];
  logic [2:0]             ps [4];
  logic [7:0]             v;
  int                     err_count = 0;
  int                     check_count = 0;
  int                     txCnt = 0;
  int                     rxCnt = 0;
  logic                   reuse = 1'b0;

  always #20 clock = ~clock;

  rpfq_payload_fifo #(.PULSE_CYC(PULSE)) rpfq_payload_fifo_inst (
    .clock(clock), .rst_n(rst_n), .clkEn(clkEn), .cmd(cmd), .cmdAddr(cmdAddr), .cmdWrData(cmdWrData),
    .cmdPipe(cmdPipe), .cmdPayload(cmdPayload), .regRdData(regRdData), .rxRdPayload(rxRdPayload),
    .txRole(txRole), .chipEnable(chipEnable), .txDone(txDone), .txStart(txStart), .txPayload(txPayload),
    .rxPush(rxPush), .rxPayload(rxPayload), .ackPipe(ackPipe), .ackTaken(ackTaken), .ackValid(ackValid),
    .ackPayload(ackPayload), .pipe4Width(pipe4Width), .pipe5Width(pipe5Width));

  rpfq_radio_model rpfq_radio_model_inst (
    .clock(clock), .rst_n(rst_n), .txStart(txStart), .txPayload(txPayload), .sendDelay(sendDelay),
    .txDone(txDone), .sentPayload(sentPayload), .sentCount(sentCount));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [255:0] rndPl();
    logic [255:0] r;
    for (int i = 0; i < 8; i++)
      r[i*32 +: 32] = rnd();
    return r;
  endfunction : rndPl
  function automatic logic [7:0] statExp();
    return {1'b0, reuse, txCnt == 3, txCnt == 0, 2'b00, rxCnt == 3, rxCnt == 0};
  endfunction : statExp
  function automatic logic [5:0] clampW(input logic [7:0] w);
    return (w[5:0] > rpfq_pkg::WIDTH_MAX) ? rpfq_pkg::WIDTH_MAX : w[5:0];
  endfunction : clampW
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic issue(input rpfq_pkg::rpfq_cmd_type c, input logic [7:0] a, input logic [2:0] p);
    @(negedge clock);
    cmd = c;
    cmdAddr = a;
    cmdPipe = p;
  endtask : issue
  // Drops the command and reads status once the command's edge has landed
  task automatic stat();
    @(negedge clock);
    cmd = rpfq_pkg::RPFQ_CMD_NONE;
    cmdAddr = rpfq_pkg::QUEUE_STATUS_ADDR;
    #1;
    chk(regRdData, statExp());
  endtask : stat
  task automatic waitSent(input logic [7:0] n);
    for (int i = 0; i < 200 && sentCount !== n; i++)
      @(negedge clock);
    chk(sentCount, n);
  endtask : waitSent
  task automatic take();
    @(negedge clock);
    ackTaken = 1'b1;
    @(negedge clock);
    ackTaken = 1'b0;
    #1;
  endtask : take

  initial
  begin
    #(40 * 30000);
    err_count++;
    complete_run();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (8) @(negedge clock);
    stat();
    chk({pipe4Width, pipe5Width, txStart, ackValid}, '0);
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    // Widths: boundaries first, then random; reserved bits 7:6 kept zero
    for (int i = 0; i < 10; i++)
    begin
      v = (i == 0) ? 8'h20 : (i == 1) ? 8'h21 : (i == 2) ? 8'h00 : (i == 3) ? 8'h3f : {2'b00, 6'(rnd() % 64)};
      cmdWrData = v;
      issue(rpfq_pkg::RPFQ_CMD_REG_WRITE, (i % 2) ? rpfq_pkg::PIPE5_RX_WIDTH_ADDR : rpfq_pkg::PIPE4_RX_WIDTH_ADDR, 3'h0);
      @(negedge clock);
      cmd = rpfq_pkg::RPFQ_CMD_NONE;
      #1;
      chk(regRdData, {2'b00, clampW(v)});
      chk((i % 2) ? pipe5Width : pipe4Width, clampW(v));
    end
    cmdAddr = 8'h18;
    #1;
    chk(regRdData, 8'h00);
    // Transmit queue filled in receiver role; fourth write must be dropped
    for (int i = 0; i < 4; i++)
    begin
      pl[i] = rndPl();
      cmdPayload = pl[i];
      issue(rpfq_pkg::RPFQ_CMD_TX_WRITE, 8'h00, 3'h0);
      txCnt = (i < 3) ? txCnt + 1 : txCnt;
      stat();
      chk(txStart, 1'b0);
    end
    clkEn = 1'b0;
    issue(rpfq_pkg::RPFQ_CMD_FLUSH_TX, 8'h00, 3'h0);
    stat();
    clkEn = 1'b1;
    txRole = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      sendDelay = (i == 0) ? 4'h0 : 4'(rnd() % 16);
      waitSent(8'(i + 1));
      chk(sentPayload, pl[i]);
    end
    repeat (30) @(negedge clock);
    chk(sentCount, 8'h03);
    txCnt = 0;
    stat();
    // Resend of the last payload
    issue(rpfq_pkg::RPFQ_CMD_RESEND_LAST, 8'h00, 3'h0);
    reuse = 1'b1;
    stat();
    chipEnable = 1'b1;
    repeat (PULSE / 2) @(negedge clock);
    chipEnable = 1'b0;
    repeat (20) @(negedge clock);
    chk(sentCount, 8'h03);
    for (int k = 0; k < 2; k++)
    begin
      chipEnable = 1'b1;
      repeat (PULSE + 1) @(negedge clock);
      chipEnable = 1'b0;
      waitSent(8'(4 + k));
      chk(sentPayload, pl[2]);
    end
    repeat (4) @(negedge clock);
    stat();
    txRole = 1'b0;
    cmdPayload = rndPl();
    issue(rpfq_pkg::RPFQ_CMD_TX_WRITE, 8'h00, 3'h0);
    reuse = 1'b0;
    txCnt = 1;
    stat();
    issue(rpfq_pkg::RPFQ_CMD_FLUSH_TX, 8'h00, 3'h0);
    txCnt = 0;
    stat();
    issue(rpfq_pkg::RPFQ_CMD_RESEND_LAST, 8'h00, 3'h0);
    stat();
    txRole = 1'b1;
    issue(rpfq_pkg::RPFQ_CMD_RESEND_LAST, 8'h00, 3'h0);
    reuse = 1'b1;
    stat();
    issue(rpfq_pkg::RPFQ_CMD_FLUSH_TX, 8'h00, 3'h0);
    reuse = 1'b0;
    stat();
    txRole = 1'b0;
    // Shared receive queue
    for (int i = 0; i < 3; i++)
    begin
      @(negedge clock);
      pl[i] = rndPl();
      rxPush = 1'b1;
      rxPayload = pl[i];
      @(negedge clock);
      rxPush = 1'b0;
      rxCnt++;
      stat();
    end
    for (int i = 0; i < 3; i++)
    begin
      chk(rxRdPayload, pl[i]);
      issue(rpfq_pkg::RPFQ_CMD_RX_READ, 8'h00, 3'h0);
      rxCnt--;
      stat();
    end
    // Receive flush drops a stored payload
    @(negedge clock);
    rxPush = 1'b1;
    @(negedge clock);
    rxPush = 1'b0;
    rxCnt = 1;
    stat();
    issue(rpfq_pkg::RPFQ_CMD_FLUSH_RX, 8'h00, 3'h0);
    rxCnt = 0;
    stat();
    // Acknowledge payloads written back to back; fourth one dropped
    ps[0] = 3'(rnd() % 3);
    ps[1] = ps[0] + 3'h3;
    ps[2] = ps[0];
    ps[3] = (ps[0] + 3'h1) % 3;
    for (int i = 0; i < 4; i++)
    begin
      pl[i] = rndPl();
      // Payload changes with the command so each write carries its own data
      issue(rpfq_pkg::RPFQ_CMD_ACK_WRITE, 8'h00, ps[i]);
      cmdPayload = pl[i];
    end
    @(negedge clock);
    cmd = rpfq_pkg::RPFQ_CMD_NONE;
    ackPipe = ps[3];
    #1;
    chk(ackValid, 1'b0);
    ackPipe = ps[0];
    txRole = 1'b1;
    #1;
    chk(ackValid, 1'b0);
    txRole = 1'b0;
    #1;
    chk({ackValid, ackPayload}, {1'b1, pl[0]});
    take();
    chk({ackValid, ackPayload}, {1'b1, pl[2]});
    take();
    chk(ackValid, 1'b0);
    ackPipe = ps[1];
    #1;
    chk({ackValid, ackPayload}, {1'b1, pl[1]});
    take();
    chk(ackValid, 1'b0);
    // Second reset in mid-run over a loaded transmit queue, then a write right after release
    cmdPayload = rndPl();
    issue(rpfq_pkg::RPFQ_CMD_TX_WRITE, 8'h00, 3'h0);
    txCnt = 1;
    stat();
    @(negedge clock);
    rst_n = 1'b0;
    #1;
    chk({pipe4Width, pipe5Width, txStart}, '0);
    txCnt = 0;
    stat();
    rst_n = 1'b1;
    issue(rpfq_pkg::RPFQ_CMD_TX_WRITE, 8'h00, 3'h0);
    txCnt = 1;
    stat();
    complete_run();
  end
endmodule : radio_payload_fifo_status_tb_top
